// >>> dft_consts.svh
// register offsets, field positions, keys and reset values
`ifndef DFT_CONSTS_SVH
`define DFT_CONSTS_SVH
`define DFT_OFF_CTRL 8'h00
`define DFT_OFF_PRECLR 8'h04
`define DFT_OFF_CLR 8'h08
`define DFT_OFF_STAT 8'h0C
`define DFT_OFF_CNTL 8'h10
`define DFT_OFF_CNTH 8'h14
`define DFT_OFF_LIML 8'h18
`define DFT_OFF_LIMH 8'h1C
`define DFT_OFF_IVL 8'h20
`define DFT_OFF_IVH 8'h24
`define DFT_OFF_HOLD 8'h28
`define DFT_CTRL_ON_BIT 15
`define DFT_ST_FIRST_KEY_BAD_FLAG_BIT 7
`define DFT_ST_SECOND_KEY_BAD_FLAG_BIT 6
`define DFT_ST_EVT_BIT 5
`define DFT_ST_WIN_BIT 0
`define DFT_FIRST_KEY 8'h40
`define DFT_SECOND_KEY 8'h08
`define DFT_KEY_RST 8'h00
`define DFT_CNT_RST 32'h0000_0000
`define DFT_HOLD_RST 16'h0000
`define DFT_UNMAPPED 16'h0000
`endif

// >>> dft_pkg.sv
// types of the deadman fetch timer
package dft_pkg;
  // progress of the two-step clear sequence
  typedef enum logic [0:0] {
    DFT_KEY_IDLE = 1'b0,
    DFT_KEY_ARMED = 1'b1
  } dft_key_t;

  // whole state of the timer block
  typedef struct packed {
    logic ctrl_on;
    dft_key_t stage;
    logic [7:0] first_key;
    logic [7:0] second_key;
    logic first_key_bad_flag;
    logic second_key_bad_flag;
    logic evt;
    logic win;
    logic [31:0] cnt;
    logic [15:0] hold;
    logic [31:0] limit;
    logic [31:0] intv;
    logic ack;
    logic [15:0] rdat;
  } dft_state_t;
endpackage

// >>> dft_deadman_timer.sv
// deadman fetch timer with a classic wishbone register slave
`timescale 1ns/1ps
`include "dft_consts.svh"
module dft_deadman_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // processor side
  input wire logic i_fetch,
  output logic o_timer_event_irq,
  // fuse words
  input wire logic i_fuse_timer_disable,
  input wire logic i_fuse_timer_enable,
  input wire logic [15:0] i_count_limit_fuse_low,
  input wire logic [15:0] i_count_limit_fuse_high,
  input wire logic [15:0] i_window_interval_fuse_low,
  input wire logic [15:0] i_window_interval_fuse_high
);

  dft_pkg::dft_state_t st_ff;
  dft_pkg::dft_state_t nxt_st;

  logic req;
  logic wr_go;
  logic rd_go;
  logic run;
  logic match;
  logic pre_wr;
  logic clr_wr;
  logic key1_bad;
  logic key2_bad;
  logic clr_ok;
  logic rd_cnt;

  // true when the byte address selects a register
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // read multiplexer, unmapped words read as zero
  function automatic logic [15:0] rd_word(
      input logic [7:0] adr, input dft_pkg::dft_state_t s);
    logic [15:0] w;
    w = `DFT_UNMAPPED;
    if (hit(adr, `DFT_OFF_CTRL)) begin
      w[`DFT_CTRL_ON_BIT] = s.ctrl_on;
    end else if (hit(adr, `DFT_OFF_PRECLR)) begin
      w[15:8] = s.first_key;
    end else if (hit(adr, `DFT_OFF_CLR)) begin
      w[7:0] = s.second_key;
    end else if (hit(adr, `DFT_OFF_STAT)) begin
      w[`DFT_ST_FIRST_KEY_BAD_FLAG_BIT] = s.first_key_bad_flag;
      w[`DFT_ST_SECOND_KEY_BAD_FLAG_BIT] = s.second_key_bad_flag;
      w[`DFT_ST_EVT_BIT] = s.evt;
      w[`DFT_ST_WIN_BIT] = s.win;
    end else if (hit(adr, `DFT_OFF_CNTL)) begin
      w = s.cnt[15:0];
    end else if (hit(adr, `DFT_OFF_CNTH)) begin
      w = s.cnt[31:16];
    end else if (hit(adr, `DFT_OFF_LIML)) begin
      w = s.limit[15:0];
    end else if (hit(adr, `DFT_OFF_LIMH)) begin
      w = s.limit[31:16];
    end else if (hit(adr, `DFT_OFF_IVL)) begin
      w = s.intv[15:0];
    end else if (hit(adr, `DFT_OFF_IVH)) begin
      w = s.intv[31:16];
    end else if (hit(adr, `DFT_OFF_HOLD)) begin
      w = s.hold;
    end
    rd_word = w;
  endfunction

  // bus strobes: data latched as ack rises, writes land as ack is seen
  assign req = i_wb_cyc & i_wb_stb;
  assign rd_go = req & ~i_wb_we & ~st_ff.ack;
  assign wr_go = req & i_wb_we & st_ff.ack;

  // fuse disable overrides both enables
  assign run = ~i_fuse_timer_disable &
               (i_fuse_timer_enable | st_ff.ctrl_on);
  assign match = (st_ff.cnt == st_ff.limit);

  // key writes only count when their byte lane is selected
  assign pre_wr = wr_go & hit(i_wb_adr, `DFT_OFF_PRECLR) & i_wb_sel[1];
  assign clr_wr = wr_go & hit(i_wb_adr, `DFT_OFF_CLR) & i_wb_sel[0];
  assign key1_bad = pre_wr & (i_wb_dat[15:8] != `DFT_FIRST_KEY);
  assign clr_ok = clr_wr & (st_ff.stage == dft_pkg::DFT_KEY_ARMED) &
                  (i_wb_dat[7:0] == `DFT_SECOND_KEY);
  assign key2_bad = clr_wr & ~clr_ok;
  assign rd_cnt = rd_go & (hit(i_wb_adr, `DFT_OFF_CNTL) |
                           hit(i_wb_adr, `DFT_OFF_CNTH));

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req & ~st_ff.ack;
    if (rd_go) begin
      nxt_st.rdat = rd_word(i_wb_adr, st_ff);
    end
    // hold tracks the upper half only when a half is read
    if (rd_cnt) begin
      nxt_st.hold = st_ff.cnt[31:16];
    end
    // control: only bit 15 is stored, the rest is dropped
    if (wr_go & hit(i_wb_adr, `DFT_OFF_CTRL) & i_wb_sel[1]) begin
      nxt_st.ctrl_on = i_wb_dat[`DFT_CTRL_ON_BIT];
    end
    // counting stops at the match so the event cannot be skipped
    if (run & i_fetch & ~match & ~st_ff.evt) begin
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
    end
    // window opens once the interval has been reached
    if (run & (st_ff.cnt >= st_ff.intv) & ~st_ff.evt) begin
      nxt_st.win = 1'b1;
    end
    // first step of the clear sequence
    if (pre_wr) begin
      nxt_st.first_key = i_wb_dat[15:8];
      nxt_st.stage = key1_bad ? dft_pkg::DFT_KEY_IDLE
                              : dft_pkg::DFT_KEY_ARMED;
    end
    // wrong second key keeps the first and captures the new byte
    if (key2_bad) begin
      nxt_st.second_key = i_wb_dat[7:0];
    end
    // timer reset event wipes counter, keys and hardware flags
    if (clr_ok) begin
      nxt_st.cnt = `DFT_CNT_RST;
      nxt_st.first_key = `DFT_KEY_RST;
      nxt_st.second_key = `DFT_KEY_RST;
      nxt_st.stage = dft_pkg::DFT_KEY_IDLE;
      nxt_st.first_key_bad_flag = 1'b0;
      nxt_st.second_key_bad_flag = 1'b0;
      nxt_st.evt = 1'b0;
      nxt_st.win = 1'b0;
    end
    // flag sets come last; a same-cycle clear still beats the match event
    if (key1_bad) begin
      nxt_st.first_key_bad_flag = 1'b1;
      nxt_st.evt = 1'b1;
    end
    if (key2_bad) begin
      nxt_st.second_key_bad_flag = 1'b1;
      nxt_st.evt = 1'b1;
    end
    if (run & match & ~clr_ok) begin
      nxt_st.evt = 1'b1;
      nxt_st.win = 1'b0;
    end
  end

  // state register; fuse words are captured while reset is held
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff <= '0;
      st_ff.cnt <= `DFT_CNT_RST;
      st_ff.hold <= `DFT_HOLD_RST;
      st_ff.limit <= {i_count_limit_fuse_high,
                      i_count_limit_fuse_low};
      st_ff.intv <= {i_window_interval_fuse_high,
                     i_window_interval_fuse_low};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs come straight from the state flops
  assign o_wb_ack = st_ff.ack;
  assign o_wb_dat = {16'h0000, st_ff.rdat};
  assign o_timer_event_irq = st_ff.evt;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // a single ack per request, dropped the cycle after
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (o_wb_ack |-> $past(req))
    else $error("ack without a request");

  // correct key pair zeroes counter and keys
  cnt_clear_a: assert property (clr_ok |=>
      st_ff.cnt == `DFT_CNT_RST && st_ff.first_key == `DFT_KEY_RST)
    else $error("counter not cleared by key pair");
  key_wipe_a: assert property (clr_ok |=>
      st_ff.second_key == `DFT_KEY_RST && !st_ff.first_key_bad_flag &&
      st_ff.stage == dft_pkg::DFT_KEY_IDLE)
    else $error("keys or flags survive reset event");

  // wrong keys raise their flags and the event
  first_key_bad_flag_set_a: assert property (key1_bad |=>
      st_ff.first_key_bad_flag && o_timer_event_irq)
    else $error("bad first key not flagged");
  second_key_bad_flag_keep_a: assert property (key2_bad |=>
      st_ff.second_key_bad_flag && st_ff.first_key == $past(st_ff.first_key) &&
      st_ff.second_key == $past(i_wb_dat[7:0]))
    else $error("bad second key handled wrongly");

  // counter frozen while disabled
  idle_stop_a: assert property ((!run && !clr_ok) |=>
      $stable(st_ff.cnt))
    else $error("counter moved while disabled");
  fuse_off_a: assert property (i_fuse_timer_disable |-> !run)
    else $error("fuse disable did not stop timer");

  // match raises event and the counter stays put
  match_evt_a: assert property ((run && match && !clr_ok) |=>
      o_timer_event_irq ##1 ($past(clr_ok) || $stable(st_ff.cnt)))
    else $error("match did not raise event");

  // hold changes only through a counter read
  hold_read_a: assert property (!rd_cnt |=>
      $stable(st_ff.hold))
    else $error("hold changed without a read");
  hold_load_a: assert property (rd_cnt |=>
      st_ff.hold == $past(st_ff.cnt[31:16]))
    else $error("hold missed upper half");

  // reserved control bits read zero
  ctrl_zero_a: assert property ((o_wb_ack && !i_wb_we &&
      hit(i_wb_adr, `DFT_OFF_CTRL)) |-> o_wb_dat[14:0] == 15'h0000)
    else $error("reserved control bits nonzero");

  // further checks on counting, window, fuse mirrors, control, keys, flags and bus timing
  // each one guards its path on every edge out of reset, not only where a directed test looks
  // counter moves by exactly one per accepted fetch; anything else
  // would let a runaway loop stretch the deadline
  cnt_step_a: assert property ((run && i_fetch && !match &&
      !st_ff.evt && !clr_ok) |=>
      st_ff.cnt == $past(st_ff.cnt) + 32'h0000_0001)
    else $error("counter did not step on a fetch");

  // no fetch, no count: a sleeping core must not age the timer
  cnt_idle_a: assert property ((!i_fetch && !clr_ok) |=>
      $stable(st_ff.cnt))
    else $error("counter moved without a fetch");

  // window opens one edge after the interval is reached
  win_open_a: assert property ((run && !st_ff.evt && !match &&
      !clr_ok && st_ff.cnt >= st_ff.intv) |=> st_ff.win)
    else $error("clear window did not open");

  // a clear, or a match while the timer runs, shuts the window
  win_shut_a: assert property ((clr_ok || (run && match)) |=>
      !st_ff.win)
    else $error("clear window left open");

  // the window cannot open on its own while the timer is stopped
  win_idle_a: assert property ((!run && !clr_ok && !st_ff.win) |=>
      !st_ff.win)
    else $error("window opened while stopped");

  // fuse mirrors are frozen after reset; software cannot move them
  fuse_keep_a: assert property (1'b1 |=>
      $stable(st_ff.limit) && $stable(st_ff.intv))
    else $error("fuse mirror changed after reset");

  // only the enable bit of a control write is kept
  ctrl_store_a: assert property ((wr_go && i_wb_sel[1] &&
      hit(i_wb_adr, `DFT_OFF_CTRL)) |=>
      st_ff.ctrl_on == $past(i_wb_dat[`DFT_CTRL_ON_BIT]))
    else $error("control enable bit not stored");

  // a good first key arms the sequence and is kept for read back
  first_arm_a: assert property ((pre_wr && !key1_bad) |=>
      st_ff.stage == dft_pkg::DFT_KEY_ARMED &&
      st_ff.first_key == `DFT_FIRST_KEY)
    else $error("good first key did not arm");

  // a bad first key disarms so a later second key cannot clear
  stage_drop_a: assert property (key1_bad |=>
      st_ff.stage == dft_pkg::DFT_KEY_IDLE)
    else $error("bad first key left sequence armed");

  // a second key sent without arming is refused like a wrong one
  cold_key_a: assert property ((clr_wr &&
      st_ff.stage == dft_pkg::DFT_KEY_IDLE) |=> st_ff.second_key_bad_flag)
    else $error("unarmed second key not refused");

  // upper half read returns the bits of the edge it was taken on
  cnt_high_a: assert property ((rd_go &&
      hit(i_wb_adr, `DFT_OFF_CNTH)) |=>
      o_wb_dat[15:0] == $past(st_ff.cnt[31:16]))
    else $error("upper counter half read wrongly");

  // event is sticky until a good key pair, so a late poll still sees it
  evt_stay_a: assert property ((st_ff.evt && !clr_ok) |=>
      o_timer_event_irq)
    else $error("timer event dropped on its own");

  // the reset event clears the remaining hardware flags too
  flag_wipe_a: assert property (clr_ok |=>
      !st_ff.second_key_bad_flag && !o_timer_event_irq)
    else $error("second bad flag or event survived clear");

  // every request is answered on the very next edge
  ack_next_a: assert property ((req && !o_wb_ack) |=> o_wb_ack)
    else $error("request not answered in one cycle");

  // main scenarios
  clear_seq_c: cover property (pre_wr && !key1_bad ##[1:20] clr_ok);
  count_match_c: cover property (run && match ##1 o_timer_event_irq);
  bad_key_c: cover property (key1_bad);
  window_c: cover property ($rose(st_ff.win));
  hold_high_c: cover property (rd_cnt && st_ff.cnt[31:16] != 16'h0000);

endmodule

// >>> tb_deadman_fetch_timer.sv
// self-checking bench for the deadman fetch timer register block
`timescale 1ns/1ps
`include "dft_consts.svh"
module tb_deadman_fetch_timer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic fetch = 1'b0;
  logic irq;
  logic fuse_dis = 1'b0;
  logic fuse_en = 1'b0;
  logic [15:0] lim_hi = 16'h0000;
  logic [15:0] q;
  int n_errors = 0;
  int n_tests = 0;

  // 50 MHz system clock
  always #10 clk = ~clk;

  // small fuse limit and interval keep match runs short
  dft_deadman_timer dut (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_fetch(fetch), .o_timer_event_irq(irq),
    .i_fuse_timer_disable(fuse_dis), .i_fuse_timer_enable(fuse_en),
    .i_count_limit_fuse_low(16'h0010), .i_count_limit_fuse_high(lim_hi),
    .i_window_interval_fuse_low(16'h0008),
    .i_window_interval_fuse_high(16'h0000)
  );

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, output logic [15:0] r);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t bus answer missing", $time);
      complete_run();
    end
    r = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, string m);
    wb(1'b0, a, 16'h0000, q);
    chk(q, e, m);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d, q);
  endtask

  // exactly n fetch cycles
  task automatic fetches(input int n);
    fetch <= 1'b1;
    repeat (n) @(posedge clk);
    fetch <= 1'b0;
  endtask

  task automatic t_reset();
    rd(`DFT_OFF_CTRL, 16'h0000, "ctrl reset");
    rd(`DFT_OFF_STAT, 16'h0000, "status reset");
    rd(`DFT_OFF_HOLD, 16'h0000, "hold reset");
    rd(`DFT_OFF_LIML, 16'h0010, "limit low");
    rd(`DFT_OFF_LIMH, 16'h0000, "limit high");
    rd(`DFT_OFF_IVL, 16'h0008, "interval low");
    rd(`DFT_OFF_IVH, 16'h0000, "interval high");
    rd(8'h30, 16'h0000, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_ctrl();
    wr(`DFT_OFF_CTRL, 16'hFFFF);
    rd(`DFT_OFF_CTRL, 16'h8000, "ctrl loose bits");
    fetches(5);
    rd(`DFT_OFF_CNTL, 16'h0005, "count while on");
    wr(`DFT_OFF_CTRL, 16'h0000);
    fetches(3);
    rd(`DFT_OFF_CNTL, 16'h0005, "count while off");
    $display("test control done");
  endtask

  task automatic t_keys();
    wr(`DFT_OFF_CTRL, 16'h8000);
    wr(`DFT_OFF_PRECLR, 16'h4000);
    wr(`DFT_OFF_CLR, 16'h0008);
    rd(`DFT_OFF_CNTL, 16'h0000, "good pair clears");
    wr(`DFT_OFF_PRECLR, 16'h1200);
    rd(`DFT_OFF_STAT, 16'h00A0, "bad first key");
    chk({15'h0000, irq}, 16'h0001, "irq on bad key");
    wr(`DFT_OFF_PRECLR, 16'h4000);
    wr(`DFT_OFF_CLR, 16'h0008);
    rd(`DFT_OFF_STAT, 16'h0000, "flags cleared");
    wr(`DFT_OFF_PRECLR, 16'h4000);
    wr(`DFT_OFF_CLR, 16'h0055);
    rd(`DFT_OFF_STAT, 16'h0060, "bad second key");
    rd(`DFT_OFF_CLR, 16'h0055, "second key captured");
    rd(`DFT_OFF_PRECLR, 16'h4000, "first key kept");
    wr(`DFT_OFF_PRECLR, 16'h4000);
    wr(`DFT_OFF_CLR, 16'h0008);
    rd(`DFT_OFF_STAT, 16'h0000, "keys reset");
    rd(`DFT_OFF_PRECLR, 16'h0000, "first key wiped");
    rd(`DFT_OFF_CLR, 16'h0000, "second key wiped");
    $display("test keys done");
  endtask

  task automatic t_match();
    fetches(9);
    rd(`DFT_OFF_CNTL, 16'h0009, "count nine");
    rd(`DFT_OFF_STAT, 16'h0001, "window open");
    fetches(20);
    rd(`DFT_OFF_CNTL, 16'h0010, "stop at match");
    rd(`DFT_OFF_CNTH, 16'h0000, "count high");
    rd(`DFT_OFF_STAT, 16'h0020, "event at match");
    chk({15'h0000, irq}, 16'h0001, "irq at match");
    rd(`DFT_OFF_HOLD, 16'h0000, "hold after read");
    $display("test match done");
  endtask

  // mid-run reset with new fuses; long count reaches the upper half
  task automatic t_fuse();
    rst_n <= 1'b0;
    fuse_dis <= 1'b1;
    fuse_en <= 1'b1;
    lim_hi <= 16'h0001;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`DFT_OFF_LIMH, 16'h0001, "limit high again");
    rd(`DFT_OFF_HOLD, 16'h0000, "hold cleared by reset");
    wr(`DFT_OFF_CTRL, 16'h8000);
    fetches(3);
    rd(`DFT_OFF_CNTL, 16'h0000, "fuse disable wins");
    fuse_dis <= 1'b0;
    wr(`DFT_OFF_CTRL, 16'h0000);
    fetches(65538);
    rd(`DFT_OFF_CNTL, 16'h0002, "fuse enable counts");
    rd(`DFT_OFF_HOLD, 16'h0001, "hold keeps upper half");
    $display("test fuse done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ctrl();
    t_keys();
    t_match();
    t_fuse();
    complete_run();
  end
endmodule
